/* bench/host_model.sv */
`timescale 1ns/1ps
module host_model (
  // bus side
  input  wire logic                    mclk,
  input  wire logic [7:0]              rdata,
  output threshold_regs_pkg::reg_req_s req
);
  initial req = '0;
  task automatic xfer(input logic w, input logic [7:0] a, d, output logic [7:0] q);
    req <= '{w, !w, a, d};
    @(posedge mclk);
    req <= '0;
    @(posedge mclk);
    q = rdata;
  endtask
endmodule

/* bench/tb_sensor_threshold_irq_regs.sv */
`timescale 1ns/1ps
module tb_sensor_threshold_irq_regs;
  logic mclk = 0, rst = 1, prox_done = 0, light_done = 0, limit_irq_en = 1, int_n;
  logic limit_source_select = 0, prox_irq_en = 0, light_irq_en = 0;
  logic [15:0] prox_result = 0, light_result = 0, lower_limit = 16'h0100, upper_limit;
  logic [2:0] persist_code = 0;
  logic [7:0] rdata, q;
  threshold_regs_pkg::reg_req_s req;
  threshold_regs_pkg::mod_timing_s mod_timing;
  int failures = 0, samples_checked = 0, cyc = 0;
  always #2.5 mclk = ~mclk;
  host_model host_model_inst (.mclk, .rdata, .req);
  sensor_threshold_irq_regs sensor_threshold_irq_regs_inst (
    .mclk                (mclk),
    .rst                 (rst),
    .req                 (req),
    .rdata               (rdata),
    .prox_done           (prox_done),
    .prox_result         (prox_result),
    .light_done          (light_done),
    .light_result        (light_result),
    .lower_limit         (lower_limit),
    .limit_irq_en        (limit_irq_en),
    .limit_source_select (limit_source_select),
    .persist_code        (persist_code),
    .prox_irq_en         (prox_irq_en),
    .light_irq_en        (light_irq_en),
    .upper_limit         (upper_limit),
    .mod_timing          (mod_timing),
    .int_n               (int_n)
  );
  task automatic check(input string n, input logic [15:0] s, e);
    samples_checked++;
    if (s !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rw(input logic w, input logic [7:0] a, d);
    host_model_inst.xfer(w, a, d, q);
  endtask
  task automatic smp(input logic s, input logic [15:0] v);
    {light_done, light_result, prox_done, prox_result} <= s ? {1'b1, v, 17'h0} : {17'h0, 1'b1, v};
    @(posedge mclk);
    {light_done, prox_done} <= 2'b00;
    @(posedge mclk);
  endtask
  task automatic flags(input logic [7:0] e, input logic irq);
    rw(0, 8'h8e, 8'h00);
    check("flags", q, e);
    check("int_n", int_n, irq);
  endtask
  task t_regs;
    rw(0, 8'h8f, 8'h00);
    check("timing reset", q, 8'h01);
    check("upper reset", upper_limit, 16'h0000);
    rw(1, 8'h8c, 8'h12);
    rw(1, 8'h8d, 8'h34);
    rw(1, 8'h8f, 8'ha9);
    check("upper", upper_limit, 16'h1234);
    rw(0, 8'h8d, 8'h00);
    check("upper low", q, 8'h34);
    check("timing", {mod_timing.delay, mod_timing.freq, mod_timing.dead}, 8'ha9);
    rw(1, 8'h8f, 8'h01);
  endtask
  task t_above;
    persist_code <= 3'h1;
    smp(0, 16'h1235);
    flags(8'h00, 1);
    smp(0, 16'h1235);
    flags(8'h01, 0);
    smp(0, 16'h0200);
    rw(1, 8'h8e, 8'hfe);
    flags(8'h01, 0);
    rw(1, 8'h8e, 8'h01);
    flags(8'h00, 1);
  endtask
  task t_below;
    persist_code <= 3'h0;
    limit_source_select <= 1;
    smp(0, 16'h0001);
    flags(8'h00, 1);
    smp(1, 16'h0001);
    flags(8'h02, 0);
    smp(1, 16'h0200);
    rw(1, 8'h8e, 8'h02);
    limit_irq_en <= 0;
    smp(1, 16'h0001);
    flags(8'h00, 1);
    limit_irq_en <= 1;
  endtask
  task t_done;
    {prox_irq_en, light_irq_en, limit_source_select} <= 3'b110;
    smp(0, 16'hffff);
    smp(1, 16'h0200);
    flags(8'h0d, 0);
    rw(1, 8'h8e, 8'h0f);
    flags(8'h00, 1);
  endtask
  task conclude;
    if (failures == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge mclk);
    rst <= 0;
    @(posedge mclk);
    t_regs;
    t_above;
    t_below;
    t_done;
    conclude;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      failures++;
      conclude;
    end
  end
endmodule

/* bench/threshold_regs_sva.sv */
`timescale 1ns/1ps
module threshold_regs_sva (
  // clock and reset
  input wire logic                       mclk,
  input wire logic                       rst,
  // register access
  input threshold_regs_pkg::reg_req_s    req,
  input wire logic [7:0]                 rdata,
  // measurement engines
  input wire logic                       prox_done,
  input wire logic [15:0]                prox_result,
  input wire logic                       light_done,
  input wire logic [15:0]                light_result,
  // interrupt control
  input wire logic [15:0]                lower_limit,
  input wire logic                       limit_irq_en,
  input wire logic                       limit_source_select,
  input wire logic [2:0]                 persist_code,
  // outputs
  input wire logic [15:0]                upper_limit,
  input threshold_regs_pkg::mod_timing_s mod_timing,
  input wire logic                       int_n
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_wr(a); req.wr && req.addr == a; endsequence
  sequence s_above; prox_done && limit_irq_en && !limit_source_select && persist_code == 0
    && prox_result > upper_limit; endsequence
  sequence s_below; light_done && limit_irq_en && limit_source_select && persist_code == 0
    && light_result < lower_limit; endsequence
  a_upper_hi_wr: assert property (s_wr(8'h8c) |=> upper_limit[15:8] == $past(req.wdata))
    else $error("upper high byte not written");
  a_upper_lo_wr: assert property (s_wr(8'h8d) |=> upper_limit[7:0] == $past(req.wdata))
    else $error("upper low byte not written");
  a_timing_wr: assert property (s_wr(8'h8f) |=> mod_timing == $past(req.wdata))
    else $error("timing not written");
  a_timing_rst: assert property ($past(rst) |-> mod_timing == 8'h01)
    else $error("timing reset value wrong");
  a_above_irq: assert property (s_above |=> !int_n)
    else $error("above event without interrupt");
  a_below_irq: assert property (s_below |=> !int_n)
    else $error("below event without interrupt");
  a_flag_hold: assert property (!int_n && !(req.wr && req.addr == 8'h8e) |=> !int_n)
    else $error("flag dropped without clear");
  a_int_release: assert property (s_wr(8'h8e) && req.wdata[3:0] == 4'hf && !prox_done
    && !light_done |=> int_n)
    else $error("interrupt held after full clear");
  a_flags_top: assert property (req.rd && req.addr == 8'h8e |=> rdata[7:4] == 4'h0)
    else $error("status upper bits not zero");
endmodule
bind sensor_threshold_irq_regs threshold_regs_sva threshold_regs_sva_inst (
  .mclk                (mclk),
  .rst                 (rst),
  .req                 (req),
  .rdata               (rdata),
  .prox_done           (prox_done),
  .prox_result         (prox_result),
  .light_done          (light_done),
  .light_result        (light_result),
  .lower_limit         (lower_limit),
  .limit_irq_en        (limit_irq_en),
  .limit_source_select (limit_source_select),
  .persist_code        (persist_code),
  .upper_limit         (upper_limit),
  .mod_timing          (mod_timing),
  .int_n               (int_n)
);

/* include/threshold_regs_params.svh */
`ifndef THRESHOLD_REGS_PARAMS_SVH
`define THRESHOLD_REGS_PARAMS_SVH
`define OFS_UPPER_HI      8'h8c
`define OFS_UPPER_LO      8'h8d
`define OFS_FLAGS         8'h8e
`define OFS_MOD_TIMING    8'h8f
`define OFS_AMB_IR        8'h90
`define BIT_PROX_DONE     3
`define BIT_LIGHT_DONE    2
`define BIT_BELOW         1
`define BIT_ABOVE         0
`define MOD_DELAY_HI      7
`define MOD_DELAY_LO      5
`define MOD_FREQ_HI       4
`define MOD_FREQ_LO       3
`define MOD_DEAD_HI       2
`define MOD_DEAD_LO       0
`define RST_MOD_TIMING    8'h01
`define RST_UPPER         16'h0000
`define RST_FLAGS         4'h0
`endif

/* include/threshold_regs_pkg.sv */
package threshold_regs_pkg;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;
  typedef struct packed {
    logic [2:0] delay;
    logic [1:0] freq;
    logic [2:0] dead;
  } mod_timing_s;
endpackage

/* rtl/sensor_threshold_irq_regs.sv */
// Operation
// R01 - upper limit as two RW bytes 8Ch/8Dh
// R02 - status register at 8Eh reports events
// R03 - below lower limit sets below flag
// R04 - above upper limit sets above flag
// R05 - flags latch until cleared
// R06 - writing one clears flag; zero ignored
// R07 - interrupt low while any flag set
// R08 - modulator timing register at 8Fh RW
// R09 - timing resets to delay0 dead1 freq0
// R10 - host programs timing value 1
// R11 - host never uses 90h register
// R12 - timing fields: delay, frequency, dead time
// R13 - status bit layout, upper bits zero
// R14 - source select: proximity or ambient
// R15 - persistence 1 to 128 consecutive measurements
`timescale 1ns/1ps
`include "threshold_regs_params.svh"
module sensor_threshold_irq_regs #(
  parameter int DW = 16
) (
  // clock and reset
  input  wire logic                            mclk,
  input  wire logic                            rst,
  // register access from the serial front end
  input  threshold_regs_pkg::reg_req_s         req,
  output logic [7:0]                           rdata,
  // measurement engines
  input  wire logic                            prox_done,
  input  wire logic [DW-1:0]                   prox_result,
  input  wire logic                            light_done,
  input  wire logic [DW-1:0]                   light_result,
  // interrupt control held elsewhere in the map
  input  wire logic [DW-1:0]                   lower_limit,
  input  wire logic                            limit_irq_en,
  input  wire logic                            limit_source_select,
  input  wire logic [2:0]                      persist_code,
  input  wire logic                            prox_irq_en,
  input  wire logic                            light_irq_en,
  // outputs
  output logic [DW-1:0]                        upper_limit,
  output threshold_regs_pkg::mod_timing_s      mod_timing,
  output logic                                 int_n
);
  localparam int                   FW        = 4;
  localparam int                   CW        = 8;
  localparam logic [FW-1:0]        FLAGS_RST = `RST_FLAGS;

  // limit comparison and persistence
  logic [DW-1:0]                   sample;
  logic                            sample_vld;
  logic [CW-1:0]                   persist_need;
  logic                            is_above;
  logic                            is_below;
  logic                            hit_above;
  logic                            hit_below;
  logic [CW-1:0]                   above_cnt_r, above_cnt_nxt;
  logic [CW-1:0]                   below_cnt_r, below_cnt_nxt;
  // status flags and interrupt pin
  logic                            wr_flags;
  logic [FW-1:0]                   set_v;
  logic [FW-1:0]                   clr_v;
  wire  [FW-1:0]                   flags_r;
  wire  [FW-1:0]                   flags_nxt;
  logic                            int_n_r, int_n_nxt;
  // host registers
  logic [DW-1:0]                   upper_r, upper_nxt;
  threshold_regs_pkg::mod_timing_s mod_r, mod_nxt;
  logic [7:0]                      rdata_r, rdata_nxt;

  // pick the source that the limits apply to
  always_comb begin
    sample       = limit_source_select ? light_result : prox_result; // R14
    sample_vld   = limit_source_select ? light_done : prox_done; // R14
    persist_need = CW'(8'h01 << persist_code); // R15
    is_above     = sample > upper_r; // R04
    is_below     = sample < lower_limit; // R03
  end

  // consecutive out-of-limit samples; saturating so a long run cannot wrap
  always_comb begin
    above_cnt_nxt = above_cnt_r;
    below_cnt_nxt = below_cnt_r;
    hit_above     = 1'b0;
    hit_below     = 1'b0;
    if (sample_vld) begin
      if (is_above) begin
        if (above_cnt_r != {CW{1'b1}}) begin
          above_cnt_nxt = CW'(above_cnt_r + 1'b1); // R15
        end
      end else begin
        above_cnt_nxt = {CW{1'b0}}; // R15
      end
      if (is_below) begin
        if (below_cnt_r != {CW{1'b1}}) begin
          below_cnt_nxt = CW'(below_cnt_r + 1'b1); // R15
        end
      end else begin
        below_cnt_nxt = {CW{1'b0}}; // R15
      end
      // the event fires once, on the sample that completes the run
      hit_above = limit_irq_en && is_above && (CW'(above_cnt_r + 1'b1) == persist_need); // R04
      hit_below = limit_irq_en && is_below && (CW'(below_cnt_r + 1'b1) == persist_need); // R03
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      above_cnt_r <= {CW{1'b0}};
      below_cnt_r <= {CW{1'b0}};
    end else begin
      above_cnt_r <= above_cnt_nxt;
      below_cnt_r <= below_cnt_nxt;
    end
  end

  // event and clear vectors in status bit order
  always_comb begin
    wr_flags               = req.wr && (req.addr == `OFS_FLAGS);
    set_v                  = {FW{1'b0}};
    set_v[`BIT_PROX_DONE]  = prox_done && prox_irq_en; // R02
    set_v[`BIT_LIGHT_DONE] = light_done && light_irq_en; // R02
    set_v[`BIT_BELOW]      = hit_below; // R03
    set_v[`BIT_ABOVE]      = hit_above; // R04
    clr_v                  = wr_flags ? req.wdata[FW-1:0] : {FW{1'b0}}; // R06
  end

  // one set-clear-hold cell per status bit
  for (genvar gi = 0; gi < FW; gi++) begin : g_flag
    logic bit_r;
    logic bit_nxt;
    always_comb begin
      // a new event wins over a clear in the same cycle
      bit_nxt = (bit_r & ~clr_v[gi]) | set_v[gi]; // R05 R06
    end
    always_ff @(posedge mclk) begin
      if (rst) begin
        bit_r <= FLAGS_RST[gi];
      end else begin
        bit_r <= bit_nxt;
      end
    end
    assign flags_r[gi]   = bit_r;
    assign flags_nxt[gi] = bit_nxt;
  end

  // the pin follows the flags that stand next cycle
  always_comb begin
    int_n_nxt = ~(|flags_nxt); // R07
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      int_n_r <= 1'b1;
    end else begin
      int_n_r <= int_n_nxt;
    end
  end

  // host writes to the limit and timing bytes
  always_comb begin
    upper_nxt = upper_r;
    mod_nxt   = mod_r;
    if (req.wr) begin
      case (req.addr)
        `OFS_UPPER_HI: begin
          upper_nxt[DW-1:8] = (DW-8)'(req.wdata); // R01
        end
        `OFS_UPPER_LO: begin
          upper_nxt[7:0] = req.wdata; // R01
        end
        `OFS_MOD_TIMING: begin
          mod_nxt = threshold_regs_pkg::mod_timing_s'(req.wdata); // R08 R12
        end
        default: begin
          upper_nxt = upper_r;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      upper_r <= DW'(`RST_UPPER);
      mod_r   <= threshold_regs_pkg::mod_timing_s'(`RST_MOD_TIMING); // R09
    end else begin
      upper_r <= upper_nxt;
      mod_r   <= mod_nxt;
    end
  end

  // reads of unmapped or reserved bytes return zero
  always_comb begin
    rdata_nxt = rdata_r;
    if (req.rd) begin
      case (req.addr)
        `OFS_UPPER_HI: begin
          rdata_nxt = 8'(upper_r[DW-1:8]); // R01
        end
        `OFS_UPPER_LO: begin
          rdata_nxt = upper_r[7:0]; // R01
        end
        `OFS_FLAGS: begin
          rdata_nxt = {{(8-FW){1'b0}}, flags_r}; // R02 R13
        end
        `OFS_MOD_TIMING: begin
          rdata_nxt = mod_r; // R12
        end
        `OFS_AMB_IR: begin
          rdata_nxt = 8'h00;
        end
        default: begin
          rdata_nxt = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata       = rdata_r;
  assign upper_limit = upper_r;
  assign mod_timing  = mod_r;
  assign int_n       = int_n_r;
endmodule
